// ### logic/pqc_counter.sv
// Pulse and quadrature counter with an APB register slave.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pqc_counter
    import pqc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [PQC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  pulseInputA,
    input  wire logic                  pulseInputB,
    input  wire logic                  lowFreqSampleClock,
    output logic [PQC_CNT_W-1:0]       counterValue,
    output logic                       headingStatus
);

    // Whole module state.
    typedef struct packed {
        pqc_sync_t              syncA;
        pqc_sync_t              syncB;
        pqc_sync_t              syncClk;
        logic                   filtLevel;
        logic [PQC_GLITCH_SUPPRESS_ENABLE_W-1:0]  filtCount;
        logic                   bAtRise;
        logic                   bAtFall;
        pqc_ctrl_t              ctrl;
        logic [PQC_CNT_W-1:0]   top;
        logic [PQC_CNT_W-1:0]   cnt;
        pqc_flags_t             flags;
        logic                   heading;
        logic [31:0]            rdata;
        logic                   rdErr;
    } pqc_state_t;

    pqc_state_t st;
    pqc_state_t next_st;

    logic       tick;
    logic       aRise;
    logic       aFall;
    logic       sample;
    logic       newFilt;
    logic       countEvt;
    logic       countDown;
    logic       quadDir;
    logic       setUf;
    logic       setOf;
    logic       setRev;
    logic       setup;
    logic       access;
    logic       mapped;
    logic [2:0] clrMask;

    // Advances one synchroniser; the level only moves once stages two and three agree.
    function automatic pqc_sync_t syncStep(input pqc_sync_t cur, input logic pin);
        pqc_sync_t res;
        res       = cur;
        res.stage = {cur.stage[1:0], pin};
        res.prev  = cur.level;
        if (cur.stage[1] == cur.stage[2]) begin
            res.level = cur.stage[2];
        end
        return res;
    endfunction : syncStep

    // Bus phases and address decode.
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign pready = access;

    always_comb begin
        if (paddr == PQC_OFS_CTRL) begin
            mapped = 1'b1;
        end else if (paddr == PQC_OFS_STATUS) begin
            mapped = 1'b1;
        end else if (paddr == PQC_OFS_CNT) begin
            mapped = 1'b1;
        end else if (paddr == PQC_OFS_TOP) begin
            mapped = 1'b1;
        end else if (paddr == PQC_OFS_FLAG) begin
            mapped = 1'b1;
        end else if (paddr == PQC_OFS_FLAGCLR) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Edges of synchronised input A and rising edges of the sample clock.
    assign tick  = st.syncClk.level & ~st.syncClk.prev;
    assign aRise = st.syncA.level & ~st.syncA.prev;
    assign aFall = ~st.syncA.level & st.syncA.prev;

    // Sampled input A after the polarity choice.
    assign sample = st.syncA.level ^ st.ctrl.edgeSelect;  // R5

    // Filtered level that feeds the sampled mode edge detector.
    always_comb begin
        newFilt = st.filtLevel;
        if (tick) begin  // R3
            if (!st.ctrl.glitchSuppressEnable) begin
                newFilt = sample;
            end else if (sample != st.filtLevel && st.filtCount == PQC_GLITCH_SUPPRESS_ENABLE_LAST) begin
                newFilt = sample;  // R19
            end
        end
    end

    // Quadrature direction from the B sample at the rising edge of A; edge select inverts it.
    always_comb begin
        if (aRise) begin
            quadDir = st.syncB.level ^ st.ctrl.edgeSelect;  // R13
        end else begin
            quadDir = st.bAtRise ^ st.ctrl.edgeSelect;  // R14
        end
    end

    // Count event and direction per mode; direction one means counting down.
    always_comb begin
        countEvt  = 1'b0;
        countDown = st.ctrl.countSenseBit;  // R6
        if (st.ctrl.auxInputSetsSense) begin
            countDown = st.syncB.level ? st.ctrl.countSenseBit : ~st.ctrl.countSenseBit;  // R7
        end
        case (st.ctrl.mode)
            PQC_MODE_SAMPLED: begin
                countEvt = newFilt & ~st.filtLevel;  // R3
            end
            PQC_MODE_PINSGL: begin
                countEvt = aRise;  // R8 R10 R21
            end
            PQC_MODE_PINQUAD: begin
                countDown = quadDir;  // R12
                if (aRise) begin
                    countEvt = st.syncB.level ^ st.bAtFall;  // R11 R14
                end else if (aFall) begin
                    countEvt = st.bAtRise ^ st.syncB.level;  // R14
                end
            end
            default: begin
                countEvt = 1'b0;  // R22
            end
        endcase
    end

    // Event flags raised by a counted pulse.
    assign setUf  = countEvt & countDown & (st.cnt == PQC_CNT_RST);  // R20
    assign setOf  = countEvt & ~countDown & (st.cnt == st.top);  // R20
    assign setRev = countEvt & (st.ctrl.mode == PQC_MODE_PINQUAD)
                    & (countDown != st.heading);  // R16

    assign clrMask = (access & pwrite & (paddr == PQC_OFS_FLAGCLR)) ? pwdata[2:0] : 3'h0;

    // Next state of the whole block.
    always_comb begin
        next_st         = st;
        next_st.syncA   = syncStep(st.syncA, pulseInputA);
        next_st.syncB   = syncStep(st.syncB, pulseInputB);
        next_st.syncClk = syncStep(st.syncClk, lowFreqSampleClock);

        // Filter counter runs on sample ticks while the filtered level disagrees.
        next_st.filtLevel = newFilt;
        if (tick) begin
            if (sample == st.filtLevel || newFilt != st.filtLevel) begin
                next_st.filtCount = '0;
            end else begin
                next_st.filtCount = st.filtCount + 3'h1;  // R4 R19
            end
        end

        // B is captured on each edge of A for the quadrature table.
        if (aRise) begin
            next_st.bAtRise = st.syncB.level;  // R11
        end
        if (aFall) begin
            next_st.bAtFall = st.syncB.level;
        end

        // Counter step with wrap or midpoint reload.
        if (countEvt) begin  // R1
            next_st.heading = countDown;  // R15
            if (setUf) begin
                next_st.cnt = st.ctrl.midpointWrapEnable ? (st.top >> 1) : st.top;  // R17 R18
            end else if (setOf) begin
                next_st.cnt = st.ctrl.midpointWrapEnable ? (st.top >> 1) : PQC_CNT_RST;  // R17 R18
            end else if (countDown) begin
                next_st.cnt = st.cnt - PQC_CNT_ONE;
            end else begin
                next_st.cnt = st.cnt + PQC_CNT_ONE;
            end
        end

        // Flags: a set in the same cycle as a clear wins.
        next_st.flags.countBelowZeroFlag = setUf
            | (st.flags.countBelowZeroFlag & ~clrMask[PQC_FLAG_UF]);
        next_st.flags.wrapPastTopFlag    = setOf
            | (st.flags.wrapPastTopFlag & ~clrMask[PQC_FLAG_OF]);
        next_st.flags.reversalFlag       = setRev
            | (st.flags.reversalFlag & ~clrMask[PQC_FLAG_REV]);

        // Writes take effect at the access edge.
        if (access & pwrite) begin
            if (paddr == PQC_OFS_CTRL) begin
                next_st.ctrl = pqc_ctrl_t'(pwdata[PQC_CTRL_AUX:PQC_CTRL_MODE_LO]);  // R2
            end else if (paddr == PQC_OFS_TOP) begin
                next_st.top = pwdata[PQC_CNT_W-1:0];
            end
        end

        // Read data is captured in the setup cycle and held through access.
        if (setup) begin
            next_st.rdErr = ~mapped;
            next_st.rdata = 32'h0000_0000;
            if (paddr == PQC_OFS_CTRL) begin
                next_st.rdata[PQC_CTRL_AUX:PQC_CTRL_MODE_LO] = st.ctrl;
            end else if (paddr == PQC_OFS_STATUS) begin
                next_st.rdata[0] = st.heading;  // R15
            end else if (paddr == PQC_OFS_CNT) begin
                next_st.rdata[PQC_CNT_W-1:0] = st.cnt;
            end else if (paddr == PQC_OFS_TOP) begin
                next_st.rdata[PQC_CNT_W-1:0] = st.top;
            end else if (paddr == PQC_OFS_FLAG) begin
                next_st.rdata[2:0] = st.flags;
            end
        end
    end

    // State register; every field takes a constant under reset.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st           <= '0;
            st.top       <= PQC_TOP_RST;
            st.cnt       <= PQC_CNT_RST;
            st.ctrl.mode <= PQC_MODE_DISABLE;
        end else begin
            st <= next_st;
        end
    end

    assign prdata        = st.rdata;
    assign pslverr       = access & st.rdErr;
    assign counterValue  = st.cnt;
    assign headingStatus = st.heading;

endmodule : pqc_counter

`default_nettype wire

// ### logic/pqc_pkg.sv
// Constants, field layouts and carrier types for the pulse and quadrature counter.
//
// Function
// R1: Keep a 16-bit counter that counts both up and down.
// R2: Sampled single mode entered by its mode value; disable value stops counting.
// R3: Sampled mode samples input A on sample clock; selected edges are counted.
// R4: In sampled mode the filter enable switches on the pulse width filter.
// R5: In sampled mode edge select inverts input A, counting falling edges.
// R6: Without aux sense, count up by default, down when count sense is set.
// R7: With aux sense, input B high keeps count sense, low reverses it.
// R8: Pin clocked single mode counts rising edges of input A directly.
// R9: Pin clocked single mode takes direction from B when aux sense set.
// R10: Pin clocked single mode has no pulse width filter, even if enabled.
// R11: Quadrature mode samples input B on both edges of input A.
// R12: A leading B counts one way, lagging the other, set automatically.
// R13: In quadrature mode edge select inverts the detected direction.
// R14: Count only when the two B samples differ; direction equals rising sample.
// R15: Current counting direction is readable as heading status.
// R16: In quadrature decoding a direction change sets the reversal flag.
// R17: Without midpoint wrap, up past top gives 0, down from 0 gives top.
// R18: With midpoint wrap, overflow and underflow load half the top value.
// R19: Filter passes an edge only after five stable sample clock levels.
// R20: Pulse at 0 counting down sets below-zero flag; at top up sets wrap flag.
// R21: In pin clocked single mode edge select has no effect.
// R22: While disabled both inputs are ignored and the counter holds.
package pqc_pkg;

    localparam int          PQC_CNT_W       = 16;
    localparam int          PQC_ADDR_W      = 12;
    localparam int          PQC_SYNC_N      = 3;
    localparam int          PQC_GLITCH_SUPPRESS_ENABLE_W      = 3;
    localparam logic [2:0]  PQC_GLITCH_SUPPRESS_ENABLE_LAST   = 3'h4;   // Five stable samples: counts 0..4.
    localparam logic [15:0] PQC_TOP_RST     = 16'hffff;
    localparam logic [15:0] PQC_CNT_RST     = 16'h0000;
    localparam logic [15:0] PQC_CNT_ONE     = 16'h0001;

    // Register byte offsets.
    localparam logic [11:0] PQC_OFS_CTRL    = 12'h000;
    localparam logic [11:0] PQC_OFS_STATUS  = 12'h008;
    localparam logic [11:0] PQC_OFS_CNT     = 12'h00c;
    localparam logic [11:0] PQC_OFS_TOP     = 12'h010;
    localparam logic [11:0] PQC_OFS_FLAG    = 12'h018;
    localparam logic [11:0] PQC_OFS_FLAGCLR = 12'h020;

    // Control field positions.
    localparam int          PQC_CTRL_MODE_LO = 0;
    localparam int          PQC_CTRL_SENSE   = 2;
    localparam int          PQC_CTRL_EDGE    = 3;
    localparam int          PQC_CTRL_GLITCH_SUPPRESS_ENABLE    = 4;
    localparam int          PQC_CTRL_MIDPOINT_WRAP_ENABLE    = 5;
    localparam int          PQC_CTRL_AUX     = 6;

    // Flag positions, shared by the flag and flag-clear registers.
    localparam int          PQC_FLAG_UF     = 0;
    localparam int          PQC_FLAG_OF     = 1;
    localparam int          PQC_FLAG_REV    = 2;

    // Mode field encodings.
    typedef enum logic [1:0] {
        PQC_MODE_DISABLE = 2'h0,
        PQC_MODE_SAMPLED = 2'h1,
        PQC_MODE_PINSGL  = 2'h2,
        PQC_MODE_PINQUAD = 2'h3
    } pqc_mode_t;

    // Software configuration.
    typedef struct packed {
        logic      auxInputSetsSense;
        logic      midpointWrapEnable;
        logic      glitchSuppressEnable;
        logic      edgeSelect;
        logic      countSenseBit;
        pqc_mode_t mode;
    } pqc_ctrl_t;

    // Sticky event flags.
    typedef struct packed {
        logic reversalFlag;
        logic wrapPastTopFlag;
        logic countBelowZeroFlag;
    } pqc_flags_t;

    // Three-stage synchroniser with the agreed level and its previous value.
    typedef struct packed {
        logic [2:0] stage;
        logic       level;
        logic       prev;
    } pqc_sync_t;

endpackage : pqc_pkg

// ### dv/pqc_encoder_model.sv
// Encoder model that drives the two pulse pins of the counter.
`timescale 1ns/1ps
`default_nettype none

module pqc_encoder_model (
    input  wire logic clk,
    output var  logic pinA,
    output var  logic pinB
);
    // Both pins rest low until the bench moves them.
    initial begin
        pinA = 1'b0;
        pinB = 1'b0;
    end

    // Toggles one pin just after an edge and holds it for the given cycles.
    task automatic flip(input bit sel, input int hold);
        @(posedge clk);
        if (sel)
            pinB <= ~pinB;
        else
            pinA <= ~pinA;
        repeat (hold) @(posedge clk);
    endtask : flip

    // Full quadrature periods; forward lets pinA lead pinB, reverse lets it lag.
    task automatic turn(input bit rev, input int periods);
        for (int i = 0; i < 4 * periods; i++)
            flip(rev ^ i[0], 6);
    endtask : turn
endmodule : pqc_encoder_model

`default_nettype wire

// ### dv/pqc_counter_checker.sv
// Port assertions for the pulse and quadrature counter.
`timescale 1ns/1ps
`default_nettype none

module pqc_counter_checker
    import pqc_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        pulseInputA,
    input wire logic        pulseInputB,
    input wire logic [15:0] counterValue,
    input wire logic        headingStatus
);
    logic [6:0]  quiet;
    logic [15:0] prevCnt;
    logic        stepUp;
    logic        stepDn;

    // Counts cycles since a pulse pin last moved, and keeps the last count.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quiet   <= 7'h00;
            prevCnt <= 16'h0000;
        end else begin
            prevCnt <= counterValue;
            if ($changed({pulseInputA, pulseInputB}))
                quiet <= 7'h00;
            else if (quiet != 7'h7f)
                quiet <= quiet + 7'h01;
        end
    end

    // A single step up or down against the previous cycle.
    assign stepUp = counterValue == 16'(prevCnt + 16'h0001);
    assign stepDn = counterValue == 16'(prevCnt - 16'h0001);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // An APB transfer is a setup cycle followed by an access cycle.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    a_setup_answer: assert property (s_setup ##1 s_access |-> pready)
        else $error("no ready in the access phase");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_error_quiet: assert property (pslverr |-> psel && penable && prdata == 32'h0)
        else $error("error response misplaced or carrying data");
    a_count_cause: assert property ($changed(counterValue) |-> quiet < 7'd60)
        else $error("counter moved without a pin event");
    a_count_step: assert property ($changed(counterValue) |-> stepUp || stepDn || counterValue == PQC_TOP_RST >> 1)
        else $error("counter jumped by more than one");
    a_up_heading: assert property ($changed(counterValue) && stepUp |-> ##[0:1] !headingStatus)
        else $error("heading not up after an up count");
    a_down_heading: assert property ($changed(counterValue) && stepDn |-> ##[0:1] headingStatus)
        else $error("heading not down after a down count");
    a_heading_cause: assert property ($changed(headingStatus) |-> quiet < 7'd60)
        else $error("heading moved without a pin event");
    a_reset_clear: assert property ($rose(resetn) |-> counterValue == 16'h0 && !headingStatus)
        else $error("counter or heading not cleared by reset");
endmodule : pqc_counter_checker

bind pqc_counter pqc_counter_checker i_pqc_counter_checker (
    .clk, .resetn, .psel, .penable, .pready, .pslverr, .prdata,
    .pulseInputA, .pulseInputB, .counterValue, .headingStatus
);

`default_nettype wire

// ### dv/test_pqc_counter.sv
// Self-checking bench for the pulse and quadrature counter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end

module test_pqc_counter
    import pqc_pkg::*;
;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic        pulseInputA, pulseInputB, lowFreqSampleClock, headingStatus;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, lastRd;
    logic [15:0] counterValue;
    logic [33:0] note;
    logic [33:0] notes[$];
    int          fail_count, n_compared, cyc, n;

    pqc_counter i_pqc_counter (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pulseInputA, .pulseInputB, .lowFreqSampleClock,
        .counterValue, .headingStatus);
    pqc_encoder_model i_pqc_encoder_model (.clk, .pinA(pulseInputA), .pinB(pulseInputB));

    // Core clock at 40 MHz and a free, unrelated 200 ns sample clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        lowFreqSampleClock = 1'b0;
        #37;
        forever #100 lowFreqSampleClock = ~lowFreqSampleClock;
    end

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    // Takes the oldest note whenever a read completes and compares it when its top bit is set.
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            lastRd = prdata;
            note = notes.pop_front();
            if (note[33])
                `CHK({pslverr, prdata}, note[32:0])
        end
    end

    // One APB transfer; a read leaves a note of the expected error bit and data.
    task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        if (!wr)
            notes.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0, {2'b10, v});
    endtask : rd
    task automatic pulse(input int k, input int hold);
        repeat (2 * k) i_pqc_encoder_model.flip(1'b0, hold);
    endtask : pulse

    // Main sequence.
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(32'h107183e3));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(PQC_OFS_CTRL, 32'h0);
        rd(PQC_OFS_TOP, 32'hffff);
        rd(PQC_OFS_FLAG, 32'h0);
        apb(1'b0, 12'h004, 32'h0, 34'h3_0000_0000);
        wr(PQC_OFS_CNT, $urandom());
        rd(PQC_OFS_CNT, 32'h0);
        pulse(2, 6);
        rd(PQC_OFS_CNT, 32'h0);
        $display("test registers and disable done");
        n = $urandom_range(5, 2);
        wr(PQC_OFS_CTRL, 32'h1a);
        pulse(n, 6);
        rd(PQC_OFS_CNT, n);
        wr(PQC_OFS_CTRL, 32'h06);
        pulse(n + 1, 6);
        rd(PQC_OFS_CNT, 32'hffff);
        rd(PQC_OFS_STATUS, 32'h1);
        rd(PQC_OFS_FLAG, 32'h1);
        wr(PQC_OFS_FLAGCLR, 32'h7);
        wr(PQC_OFS_CTRL, 32'h42);
        pulse(1, 6);
        i_pqc_encoder_model.flip(1'b1, 6);
        pulse(2, 6);
        rd(PQC_OFS_CNT, 32'h0);
        rd(PQC_OFS_FLAG, 32'h2);
        $display("test pin single done");
        // Sampled mode: a long pulse always counts, a short one only unfiltered.
        for (int f = 0; f < 2; f++) begin
            wr(PQC_OFS_CTRL, 32'h1 | f << 4);
            pulse(1, 80);
            pulse(1, 16);
            rd(PQC_OFS_CNT, 32'h2 + f);
        end
        wr(PQC_OFS_CTRL, 32'h0);
        i_pqc_encoder_model.flip(1'b0, 8);
        wr(PQC_OFS_CTRL, 32'h4d);
        pulse(1, 80);
        rd(PQC_OFS_CNT, 32'h2);
        wr(PQC_OFS_CTRL, 32'h0);
        i_pqc_encoder_model.flip(1'b0, 8);
        i_pqc_encoder_model.flip(1'b1, 8);
        $display("test sampled done");
        // Quadrature: forward, reverse, then forward with the direction inverted.
        for (int r = 0; r < 3; r++) begin
            wr(PQC_OFS_FLAGCLR, 32'h7);
            wr(PQC_OFS_CTRL, r < 2 ? 32'h3 : 32'hb);
            i_pqc_encoder_model.turn(r == 1, r == 0 ? 3 : 1);
            apb(1'b0, PQC_OFS_CNT, 32'h0, 34'h0);
            i_pqc_encoder_model.turn(r == 1, 2);
            rd(PQC_OFS_CNT, r == 0 ? lastRd + 32'h4 : lastRd - 32'h4);
            rd(PQC_OFS_STATUS, r != 0);
            rd(PQC_OFS_FLAG, r < 2 ? 32'h4 : 32'h0);
        end
        $display("test quadrature done");
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        wr(PQC_OFS_CTRL, 32'h26);
        pulse(1, 6);
        rd(PQC_OFS_CNT, PQC_TOP_RST >> 1);
        rd(PQC_OFS_FLAG, 32'h1);
        $display("test midpoint done");
        results();
    end
endmodule : test_pqc_counter

`default_nettype wire
